// ### common/aao_defines.svh
// Reset values, flag positions and fixed widths for the work register datapath
`ifndef AAO_DEFINES_SVH
`define AAO_DEFINES_SVH

`define AAO_DATA_W 8
`define AAO_WORK_RST 8'h00
`define AAO_ADDR_RST 8'h00
`define AAO_FLAG_RST 5'h00

// Bit positions and width of the packed flag vector
`define AAO_FLG_C 0
`define AAO_FLG_NIB 1
`define AAO_FLG_Z 2
`define AAO_FLG_OVF 3
`define AAO_FLG_SC 4
`define AAO_FLG_W 5

`endif

// ### common/aao_pkg.sv
// Types shared by the work register datapath
`default_nettype none
package aao_pkg;

	typedef enum logic [1:0] {
		AAO_OP_SUM_WORK_INTO_MEM = 2'h0,
		AAO_OP_CONJ_MEM_TO_WORK = 2'h1,
		AAO_OP_CONJ_IMM_TO_WORK = 2'h2,
		AAO_OP_LOGIC_CONJ_WORK_TO_MEM = 2'h3
	} aao_op_t;

	typedef enum logic [2:0] {
		AAO_ST_IDLE = 3'h1,
		AAO_ST_FETCH = 3'h2,
		AAO_ST_EXEC = 3'h4
	} aao_state_t;

	typedef struct packed {
		aao_state_t state;
		aao_op_t op;
		logic [7:0] imm;
		logic [7:0] work_register;
		logic [4:0] flags;
		logic [7:0] mem_addr;
		logic mem_re;
		logic mem_we;
		logic [7:0] mem_wdata;
		logic busy;
		logic done;
	} aao_regs_t;

endpackage
`default_nettype wire

// ### hdl/aao_adder.sv
// Byte adder with carry, nibble carry, overflow, signed carry and zero outputs
`default_nettype none
module aao_adder #(
	parameter int WIDTH = 8
)
(
	input wire logic [WIDTH-1:0] a,
	input wire logic [WIDTH-1:0] b,
	output logic [WIDTH-1:0] sum,
	output logic carry,
	output logic nibble_carry,
	output logic signed_range_fault,
	output logic signed_carry_out,
	output logic zero
);

	logic [WIDTH:0] full;
	logic [4:0] low;

	always_comb
	begin
		full = {1'b0, a} + {1'b0, b};
		low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
		sum = full[WIDTH-1:0];
		carry = full[WIDTH];
		nibble_carry = low[4];
		// Both operands share a sign that the sum does not
		signed_range_fault = (a[WIDTH-1] == b[WIDTH-1]) && (sum[WIDTH-1] != a[WIDTH-1]);
		// True sign of the signed result, valid even when the byte overflowed
		signed_carry_out = signed_range_fault ^ sum[WIDTH-1];
		zero = (sum == '0);
	end

endmodule
`default_nettype wire

// ### hdl/aao_core.sv
// Work register datapath: add-to-memory and three AND forms with flag update
`include "aao_defines.svh"
`default_nettype none

// What this block does
// - Add work register and memory byte, set flags
// - Sum goes to memory, work register kept
// - Memory AND into work register, zero only
// - AND result to work register, memory untouched
// - Immediate AND into work register, zero only
// - Work register AND memory, result to memory
module aao_core (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic op_valid,
	input wire aao_pkg::aao_op_t op_code,
	input wire logic [7:0] op_addr,
	input wire logic [7:0] op_imm,
	input wire logic [7:0] mem_rdata,
	input wire logic work_load,
	input wire logic [7:0] work_load_data,
	input wire logic flags_load,
	input wire logic [4:0] flags_load_data,
	output logic busy,
	output logic done,
	output logic mem_re,
	output logic mem_we,
	output logic [7:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic [7:0] work_register,
	output logic carry,
	output logic nibble_carry,
	output logic zero,
	output logic signed_range_fault,
	output logic signed_carry_out
);

	aao_pkg::aao_regs_t r;
	aao_pkg::aao_regs_t next_r;

	logic [7:0] add_sum;
	logic add_c;
	logic add_nib;
	logic add_ovf;
	logic add_sc;
	logic add_z;
	logic [7:0] operand;
	logic [7:0] conj;
	logic accept;

	// Memory operand arrives the cycle after the read strobe
	aao_adder #(
		.WIDTH(`AAO_DATA_W)
	)
	u_adder (
		.a(r.work_register),
		.b(mem_rdata),
		.sum(add_sum),
		.carry(add_c),
		.nibble_carry(add_nib),
		.signed_range_fault(add_ovf),
		.signed_carry_out(add_sc),
		.zero(add_z)
	);

	always_comb
	begin
		accept = op_valid && (r.state == aao_pkg::AAO_ST_IDLE);
		if (r.op == aao_pkg::AAO_OP_CONJ_IMM_TO_WORK)
		begin
			operand = r.imm;
		end
		else
		begin
			operand = mem_rdata;
		end
		conj = r.work_register & operand;
	end

	always_comb
	begin
		next_r = r;
		next_r.mem_re = 1'b0;
		next_r.mem_we = 1'b0;
		next_r.done = 1'b0;

		// Core-side loads land first so that an executing op overrides the fields it writes
		if (work_load)
		begin
			next_r.work_register = work_load_data;
		end
		if (flags_load)
		begin
			next_r.flags = flags_load_data;
		end

		case (r.state)
			aao_pkg::AAO_ST_IDLE:
			begin
				if (accept)
				begin
					next_r.op = op_code;
					next_r.imm = op_imm;
					next_r.mem_addr = op_addr;
					next_r.busy = 1'b1;
					// Immediate form needs no memory read, so it skips a cycle
					if (op_code == aao_pkg::AAO_OP_CONJ_IMM_TO_WORK)
					begin
						next_r.state = aao_pkg::AAO_ST_EXEC;
					end
					else
					begin
						next_r.mem_re = 1'b1;
						next_r.state = aao_pkg::AAO_ST_FETCH;
					end
				end
			end
			aao_pkg::AAO_ST_FETCH:
			begin
				next_r.state = aao_pkg::AAO_ST_EXEC;
			end
			aao_pkg::AAO_ST_EXEC:
			begin
				next_r.state = aao_pkg::AAO_ST_IDLE;
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
				case (r.op)
					aao_pkg::AAO_OP_SUM_WORK_INTO_MEM:
					begin
						next_r.flags[`AAO_FLG_C] = add_c;
						next_r.flags[`AAO_FLG_NIB] = add_nib;
						next_r.flags[`AAO_FLG_Z] = add_z;
						next_r.flags[`AAO_FLG_OVF] = add_ovf;
						next_r.flags[`AAO_FLG_SC] = add_sc;
						// Work register is left alone here
						next_r.work_register = r.work_register;
						next_r.mem_wdata = add_sum;
						next_r.mem_we = 1'b1;
					end
					aao_pkg::AAO_OP_CONJ_MEM_TO_WORK:
					begin
						next_r.work_register = conj;
						next_r.flags[`AAO_FLG_Z] = (conj == 8'h00);
					end
					aao_pkg::AAO_OP_CONJ_IMM_TO_WORK:
					begin
						next_r.work_register = conj;
						next_r.flags[`AAO_FLG_Z] = (conj == 8'h00);
					end
					default:
					begin
						next_r.work_register = r.work_register;
						next_r.mem_wdata = conj;
						next_r.mem_we = 1'b1;
						next_r.flags[`AAO_FLG_Z] = (conj == 8'h00);
					end
				endcase
			end
			default:
			begin
				// Illegal one-hot code: recover quietly rather than hang the core
				next_r.state = aao_pkg::AAO_ST_IDLE;
				next_r.busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			r.state <= aao_pkg::AAO_ST_IDLE;
			r.op <= aao_pkg::AAO_OP_SUM_WORK_INTO_MEM;
			r.imm <= 8'h00;
			r.work_register <= `AAO_WORK_RST;
			r.flags <= `AAO_FLAG_RST;
			r.mem_addr <= `AAO_ADDR_RST;
			r.mem_re <= 1'b0;
			r.mem_we <= 1'b0;
			r.mem_wdata <= 8'h00;
			r.busy <= 1'b0;
			r.done <= 1'b0;
		end
		else
		begin
			r <= next_r;
		end
	end

	assign busy = r.busy;
	assign done = r.done;
	assign mem_re = r.mem_re;
	assign mem_we = r.mem_we;
	assign mem_addr = r.mem_addr;
	assign mem_wdata = r.mem_wdata;
	assign work_register = r.work_register;
	assign carry = r.flags[`AAO_FLG_C];
	assign nibble_carry = r.flags[`AAO_FLG_NIB];
	assign zero = r.flags[`AAO_FLG_Z];
	assign signed_range_fault = r.flags[`AAO_FLG_OVF];
	assign signed_carry_out = r.flags[`AAO_FLG_SC];

endmodule
`default_nettype wire

// ### verif/aao_core_checker.sv
// Concurrent checks on the datapath ports
`default_nettype none
module aao_core_checker (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic op_valid,
	input wire aao_pkg::aao_op_t op_code,
	input wire logic [7:0] op_imm,
	input wire logic [7:0] mem_rdata,
	input wire logic busy,
	input wire logic done,
	input wire logic mem_re,
	input wire logic mem_we,
	input wire logic [7:0] mem_wdata,
	input wire logic [7:0] work_register,
	input wire logic carry,
	input wire logic zero
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	logic [7:0] w, i, pm;
	logic [1:0] o;
	wire t = op_valid && !busy;
	wire d0 = done && o == 2'h0;
	wire d1 = done && o == 2'h1;
	wire d2 = done && o == 2'h2;
	wire d3 = done && o == 2'h3;
	// Operands kept from the taking edge; pm is read data of the cycle before done
	always_ff @(posedge ref_clk)
	begin
		pm <= mem_rdata;
		if (t)
		begin
			w <= work_register;
			i <= op_imm;
			o <= op_code;
		end
	end
	AST_SUM: assert property (d0
		|-> {carry, mem_wdata} == w + pm && zero == !mem_wdata)
		else $error("bad sum");
	AST_SUM_WB: assert property (d0 |-> mem_we && work_register == w)
		else $error("bad sum write");
	AST_AND_MEM: assert property (d1 |-> work_register == (w & pm) && $stable(carry))
		else $error("bad and");
	AST_NO_WR: assert property (t && (op_code[1] ^ op_code[0]) |=> !mem_we [*3])
		else $error("and wrote memory");
	AST_AND_IMM: assert property (d2
		|-> work_register == (w & i) && zero == !work_register)
		else $error("bad imm and");
	AST_AND_WB: assert property (d3 |-> mem_we && mem_wdata == (w & pm))
		else $error("bad and write");
	AST_Z_ONLY: assert property (d3
		|-> zero == !mem_wdata && $stable(carry) && work_register == w)
		else $error("bad zero");
	AST_LAT: assert property (t && op_code != 2'h2 |=> mem_re ##2 done)
		else $error("bad timing");
	AST_LAT_IMM: assert property (t && op_code == 2'h2
		|=> busy && !mem_re ##1 done && !busy)
		else $error("bad imm timing");
	cover property (d0 && carry);
	cover property (d3 && zero);
	cover property (d2 && zero);
	cover property (op_valid && busy);
endmodule
`default_nettype wire

// ### verif/test_acc_add_and_ops.sv
// Self-checking bench for the work register datapath
`default_nettype none
module test_acc_add_and_ops;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'h0, srst = 1'h1, op_valid = 1'h0, work_load = 1'h0, flags_load = 1'h0;
	aao_pkg::aao_op_t op_code = aao_pkg::AAO_OP_SUM_WORK_INTO_MEM;
	logic [7:0] op_addr = 8'h00, op_imm = 8'h00, mem_rdata = 8'h00, work_load_data = 8'h00;
	logic [4:0] flags_load_data = 5'h00;
	logic busy, done, mem_re, mem_we, carry, nibble_carry, zero;
	logic signed_range_fault, signed_carry_out;
	logic [4:0] fm;
	logic [7:0] mem_addr, mem_wdata, work_register, wm, wd;
	logic [7:0] mem [4], sm [4];
	logic [21:0] q [$], e;
	int error_cnt = 0, cmp_count = 0, seed = 32'h595a96b1;
	wire [21:0] got = {mem_we, signed_carry_out, signed_range_fault, zero, nibble_carry, carry,
		work_register, mem_wdata};
	always #12.5 ref_clk = ~ref_clk;
	aao_core uut (.ref_clk, .srst, .op_valid, .op_code, .op_addr, .op_imm, .mem_rdata,
		.work_load, .work_load_data, .flags_load, .flags_load_data, .busy, .done, .mem_re,
		.mem_we, .mem_addr, .mem_wdata, .work_register, .carry, .nibble_carry, .zero,
		.signed_range_fault, .signed_carry_out);
	// Read data is inverted when not requested, so a late sample cannot pass
	always @(posedge ref_clk)
	begin
		mem_rdata <= mem_re ? mem[mem_addr[1:0]] : ~mem_rdata;
		if (mem_we)
			mem[mem_addr[1:0]] <= mem_wdata;
	end
	always @(negedge ref_clk)
		if (done === 1'h1)
		begin
			e = q.pop_front();
			cmp_count++;
			if (got !== e)
			begin
				error_cnt++;
				$display("Error %0t %h %h", $time, got, e);
			end
		end
	task automatic print_verdict;
		// A result that never showed up leaves its note behind
		if (q.size() != 0)
		begin
			error_cnt++;
			$display("Error %0t %h %h", $time, q.size(), 0);
		end
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic idle_wait;
		int n;
		n = 0;
		do
		begin
			@(negedge ref_clk);
			n++;
			if (n > 9)
			begin
				error_cnt++;
				print_verdict;
			end
		end while (busy !== 1'h0);
		@(posedge ref_clk);
	endtask
	task automatic ld(input logic [7:0] w, input logic [4:0] f);
		op_valid <= 1'h0;
		idle_wait;
		work_load <= 1'h1;
		work_load_data <= w;
		flags_load <= 1'h1;
		flags_load_data <= f;
		wm = w;
		fm = f;
		@(posedge ref_clk);
		work_load <= 1'h0;
		flags_load <= 1'h0;
	endtask
	// Request stays up while busy, so refused cycles are exercised too
	task automatic op(input logic [1:0] c, input logic [1:0] a, input logic [7:0] x);
		logic [8:0] s;
		logic [8:0] v;
		logic [4:0] h;
		logic [7:0] r;
		logic k;
		k = c[0] == c[1];
		r = c == 2'h2 ? wm & x : wm & sm[a];
		s = wm + sm[a];
		// Sign-extended sum: its top bit is the true sign of the signed result
		v = {wm[7], wm} + {sm[a][7], sm[a]};
		h = {1'b0, wm[3:0]} + {1'b0, sm[a][3:0]};
		if (c == 2'h0)
		begin
			{fm[0], r} = s;
			fm[1] = h[4];
			fm[3] = v[8] != v[7];
			fm[4] = v[8];
		end
		fm[2] = r == 8'h00;
		if (k)
		begin
			wd = r;
			sm[a] = r;
		end
		else
			wm = r;
		q.push_back({k, fm, wm, wd});
		op_code <= aao_pkg::aao_op_t'(c);
		op_addr <= {6'h00, a};
		op_imm <= x;
		op_valid <= 1'h1;
		idle_wait;
	endtask
	initial
	begin
		wd = 8'h00;
		for (int j = 0; j < 4; j++)
		begin
			mem[j] = 8'($random(seed));
			sm[j] = mem[j];
		end
		repeat (3) @(posedge ref_clk);
		srst <= 1'h0;
		@(posedge ref_clk);
		@(negedge ref_clk);
		cmp_count++;
		if ({busy, done, mem_re, mem_addr, got} !== 33'h0)
		begin
			error_cnt++;
			$display("Error %0t %h %h", $time, {busy, done, mem_re, mem_addr, got}, 33'h0);
		end
		$display("test reset values done");
		@(posedge ref_clk);
		ld(8'hff, 5'h00);
		for (int j = 0; j < 80; j++)
		begin
			if (j % 6 == 5)
				ld(8'($random(seed)), 5'($random(seed)));
			op(2'(j < 4 ? j : $random(seed)), 2'($random(seed)), 8'(j % 9 ? $random(seed) : 0));
		end
		op_valid <= 1'h0;
		idle_wait;
		$display("test random op sequence done");
		print_verdict;
	end
endmodule
bind aao_core aao_core_checker chk (.ref_clk, .srst, .op_valid, .op_code, .op_imm, .mem_rdata,
	.busy, .done, .mem_re, .mem_we, .mem_wdata, .work_register, .carry, .zero);
`default_nettype wire
